//--- src/ptp_cfg_pkg.sv
// Constants and carrier types of the time-sync configuration register bank.
// Assumes a 32-bit APB slave, one aligned word per register index.
package ptp_cfg_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int REG_W  = 16;
	localparam int ADDR_W = 8;
	localparam int IDX_W  = 6;
	localparam int DUR_HIGH_W = 10;
	localparam int DUR_W  = 26;
	localparam int DIV_W  = 8;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_PAGE_SELECT = 6'h13;
	localparam logic [IDX_W-1:0] IDX_COC         = 6'h14;
	localparam logic [IDX_W-1:0] IDX_HEADER      = 6'h15;
	localparam logic [IDX_W-1:0] IDX_SA_HIGH     = 6'h16;
	localparam logic [IDX_W-1:0] IDX_SA_LOW      = 6'h17;
	localparam logic [IDX_W-1:0] IDX_TRD_LOW     = 6'h1E;
	localparam logic [IDX_W-1:0] IDX_TRD_HIGH    = 6'h1F;
	localparam logic [IDX_W-1:0] IDX_RATE_HIGH   = 6'h20;
	localparam logic [IDX_W-1:0] IDX_RATE_LOW    = 6'h21;
	localparam logic [IDX_W-1:0] IDX_RATE_STATUS = 6'h22;

	// ----------------------------------------------------------------
	// Pages and field positions
	// ----------------------------------------------------------------
	localparam logic [2:0] PAGE_RATE  = 3'h5;
	localparam logic [2:0] PAGE_CFG   = 3'h6;
	localparam logic [2:0] PAGE_RESET = 3'h0;
	localparam int COC_EN_BIT    = 15;
	localparam int COC_SEL_BIT   = 14;
	localparam int COC_SPEED_BIT = 13;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic             COC_EN_RESET  = 1'b1;
	localparam logic             COC_SEL_RESET = 1'b0;
	localparam logic [DIV_W-1:0] DIV_RESET     = 8'h0A;
	localparam logic [DIV_W-1:0] DIV_MIN       = 8'h02;
	localparam logic [REG_W-1:0] REG_ZERO      = 16'h0000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             enable;
		logic             root_select;
		logic             speed_select;
		logic [DIV_W-1:0] divide;
	} clk_out_cfg_s;

	typedef struct packed {
		logic [3:0] reserved_nibble;
		logic [3:0] version;
		logic [3:0] transport;
		logic [3:0] message_kind;
	} header_word_s;

	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
		logic [7:0] third;
		logic [7:0] fourth;
	} source_addr_s;

endpackage

//--- src/sync_clock_divider.sv
// Divide-by-N generator for the synchronized clock output.
// Assumes cfg comes from flops on clk; clk stands in for the divider root.
`timescale 1ns/1ps
`default_nettype none
module sync_clock_divider
(
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire ptp_cfg_pkg::clk_out_cfg_s cfg,
	output logic                         sync_clk_r
);

	typedef struct packed {
		logic [ptp_cfg_pkg::DIV_W-1:0] cnt;
		logic                          out;
	} div_state_s;

	div_state_s st_r;
	div_state_s st_nxt;
	logic       run;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		// divide of 0 or 1 stops output
		run = cfg.enable && (cfg.divide >= ptp_cfg_pkg::DIV_MIN);
		if (!run)
		begin
			st_nxt.cnt = '0;
			st_nxt.out = 1'b0;
		end
		else
		begin
			if (st_r.cnt >= cfg.divide - 8'h01)
				st_nxt.cnt = '0;
			else
				st_nxt.cnt = st_r.cnt + 8'h01;
			st_nxt.out = (st_nxt.cnt < (cfg.divide >> 1));
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign sync_clk_r = st_r.out;

	AST_DIV_STOPPED: assert property (@(posedge clk) disable iff (rst)
		!run |=> !sync_clk_r)
		else $error("output clock runs while stopped");
	AST_DIV_BY_TWO: assert property (@(posedge clk) disable iff (rst)
		(cfg.enable && cfg.divide == 8'h02)[*3] |-> sync_clk_r != $past(sync_clk_r))
		else $error("divide by two does not toggle each cycle");

endmodule
`default_nettype wire

//--- src/temp_rate_counter.sv
// Down-counter that holds the temporary rate for a programmed cycle count.
// Assumes start is a one-cycle pulse from logic on clk.
`timescale 1ns/1ps
`default_nettype none
module temp_rate_counter
#(
	parameter int DUR_W = 26
)
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             start,
	input  wire logic [DUR_W-1:0] duration,
	output logic                  active_r
);

	typedef struct packed {
		logic [DUR_W-1:0] remaining;
		logic             active;
	} cnt_state_s;

	localparam logic [DUR_W-1:0] ONE = {{(DUR_W-1){1'b0}}, 1'b1};

	cnt_state_s st_r;
	cnt_state_s st_nxt;

	// ----------------------------------------------------------------
	// Count
	// ----------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		if (start)
		begin
			st_nxt.remaining = duration;
			st_nxt.active    = (duration != '0);
		end
		else if (st_r.active)
		begin
			st_nxt.remaining = st_r.remaining - ONE;
			st_nxt.active    = (st_r.remaining != ONE);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign active_r = st_r.active;

	AST_CNT_LOAD: assert property (@(posedge clk) disable iff (rst)
		start && duration == 26'h0000003 |=> active_r [*3] ##1 !active_r)
		else $error("temporary rate length wrong");
	AST_CNT_ZERO: assert property (@(posedge clk) disable iff (rst)
		start && duration == '0 |=> !active_r)
		else $error("zero duration started a temporary rate");

endmodule
`default_nettype wire

//--- src/ptp_config_register_bank.sv
// Register bank for the time-sync clock output, status frames and rate timer.
// Assumes an APB master on clk; pages gate the paged registers.
`timescale 1ns/1ps
`default_nettype none
module ptp_config_register_bank
(
	input  wire logic                                  clk,
	input  wire logic                                  rst,
	input  wire logic                                  psel,
	input  wire logic                                  penable,
	input  wire logic                                  pwrite,
	input  wire logic [ptp_cfg_pkg::ADDR_W-1:0]        paddr,
	input  wire logic [ptp_cfg_pkg::DATA_W-1:0]        pwdata,
	input  wire logic [3:0]                            pstrb,
	output logic [ptp_cfg_pkg::DATA_W-1:0]             prdata,
	output logic                                       pready,
	output logic                                       pslverr,
	output ptp_cfg_pkg::clk_out_cfg_s                  clk_out_cfg,
	output logic                                       sync_clk_out,
	output ptp_cfg_pkg::header_word_s                  status_header,
	output ptp_cfg_pkg::source_addr_s                  status_source_addr,
	output logic [2*ptp_cfg_pkg::REG_W-1:0]            temp_rate_value,
	output logic                                       temp_rate_active
);

	typedef struct packed {
		logic                                pready;
		logic                                pslverr;
		logic [ptp_cfg_pkg::DATA_W-1:0]      prdata;
		logic [2:0]                          page;
		ptp_cfg_pkg::clk_out_cfg_s           coc;
		ptp_cfg_pkg::header_word_s           hdr;
		logic [ptp_cfg_pkg::REG_W-1:0]       sa_high;
		logic [ptp_cfg_pkg::REG_W-1:0]       sa_low;
		logic [ptp_cfg_pkg::REG_W-1:0]       dur_low;
		logic [ptp_cfg_pkg::DUR_HIGH_W-1:0]  dur_high;
		logic [ptp_cfg_pkg::REG_W-1:0]       rate_high;
		logic [ptp_cfg_pkg::REG_W-1:0]       rate_low;
		logic                                start;
	} bank_state_s;

	bank_state_s                       st_r;
	bank_state_s                       st_nxt;
	logic [ptp_cfg_pkg::IDX_W-1:0]     idx;
	logic                              complete;
	logic                              write_done;
	logic [ptp_cfg_pkg::REG_W-1:0]     wdata16;
	logic                              rate_active;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	// Paged registers are visible only on their own page
	function automatic logic reg_mapped
	(
		input logic [ptp_cfg_pkg::IDX_W-1:0] i,
		input logic [2:0]                    page
	);
		logic hit;
		hit = 1'b0;
		unique case (i)
			ptp_cfg_pkg::IDX_PAGE_SELECT,
			ptp_cfg_pkg::IDX_RATE_HIGH,
			ptp_cfg_pkg::IDX_RATE_LOW,
			ptp_cfg_pkg::IDX_RATE_STATUS:
				hit = 1'b1;
			ptp_cfg_pkg::IDX_COC,
			ptp_cfg_pkg::IDX_HEADER,
			ptp_cfg_pkg::IDX_SA_HIGH,
			ptp_cfg_pkg::IDX_SA_LOW:
				hit = (page == ptp_cfg_pkg::PAGE_CFG);
			ptp_cfg_pkg::IDX_TRD_LOW,
			ptp_cfg_pkg::IDX_TRD_HIGH:
				hit = (page == ptp_cfg_pkg::PAGE_RATE);
			default:
				hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Byte lanes 0 and 1 carry a 16-bit register
	function automatic logic [ptp_cfg_pkg::REG_W-1:0] merge16
	(
		input logic [ptp_cfg_pkg::REG_W-1:0] old_val,
		input logic [ptp_cfg_pkg::REG_W-1:0] new_val,
		input logic [1:0]                    strb
	);
		logic [ptp_cfg_pkg::REG_W-1:0] v;
		v = old_val;
		if (strb[0])
			v[7:0] = new_val[7:0];
		if (strb[1])
			v[15:8] = new_val[15:8];
		return v;
	endfunction

	function automatic logic [ptp_cfg_pkg::REG_W-1:0] read16
	(
		input bank_state_s                   s,
		input logic [ptp_cfg_pkg::IDX_W-1:0] i,
		input logic                          active
	);
		logic [ptp_cfg_pkg::REG_W-1:0] v;
		v = ptp_cfg_pkg::REG_ZERO;
		unique case (i)
			ptp_cfg_pkg::IDX_PAGE_SELECT: v = {13'h0000, s.page};
			ptp_cfg_pkg::IDX_COC:
				v = {s.coc.enable, s.coc.root_select, s.coc.speed_select,
					5'h00, s.coc.divide};
			ptp_cfg_pkg::IDX_HEADER:      v = s.hdr;
			ptp_cfg_pkg::IDX_SA_HIGH:     v = s.sa_high;
			ptp_cfg_pkg::IDX_SA_LOW:      v = s.sa_low;
			ptp_cfg_pkg::IDX_TRD_LOW:     v = s.dur_low;
			ptp_cfg_pkg::IDX_TRD_HIGH:    v = {6'h00, s.dur_high};
			ptp_cfg_pkg::IDX_RATE_HIGH:   v = s.rate_high;
			ptp_cfg_pkg::IDX_RATE_LOW:    v = s.rate_low;
			ptp_cfg_pkg::IDX_RATE_STATUS: v = {15'h0000, active};
			default:                      v = ptp_cfg_pkg::REG_ZERO;
		endcase
		return v;
	endfunction

	assign idx        = paddr[ptp_cfg_pkg::IDX_W+1:2];
	assign complete   = psel && penable && st_r.pready;
	assign write_done = complete && pwrite && reg_mapped(idx, st_r.page);
	assign wdata16    = pwdata[ptp_cfg_pkg::REG_W-1:0];

	// ----------------------------------------------------------------
	// Bus slave and register update
	// ----------------------------------------------------------------
	always_comb
	begin
		st_nxt       = st_r;
		st_nxt.start = 1'b0;
		// One wait state; answer in second access cycle
		st_nxt.pready = psel && penable && !st_r.pready;
		if (psel && penable && !st_r.pready)
		begin
			st_nxt.pslverr = !reg_mapped(idx, st_r.page);
			st_nxt.prdata  = '0;
			if (!pwrite && reg_mapped(idx, st_r.page))
				st_nxt.prdata = {16'h0000, read16(st_r, idx, rate_active)};
		end
		else if (complete)
		begin
			st_nxt.pslverr = 1'b0;
			st_nxt.prdata  = '0;
		end
		if (write_done)
		begin
			unique case (idx)
				ptp_cfg_pkg::IDX_PAGE_SELECT:
					if (pstrb[0])
						st_nxt.page = pwdata[2:0];
				ptp_cfg_pkg::IDX_COC:
				begin
					if (pstrb[1])
					begin
						st_nxt.coc.enable       = pwdata[ptp_cfg_pkg::COC_EN_BIT];
						st_nxt.coc.root_select  = pwdata[ptp_cfg_pkg::COC_SEL_BIT];
						st_nxt.coc.speed_select = pwdata[ptp_cfg_pkg::COC_SPEED_BIT];
					end
					if (pstrb[0])
						st_nxt.coc.divide = pwdata[ptp_cfg_pkg::DIV_W-1:0];
				end
				ptp_cfg_pkg::IDX_HEADER:
					st_nxt.hdr = merge16(st_r.hdr, wdata16, pstrb[1:0]);
				ptp_cfg_pkg::IDX_SA_HIGH:
					st_nxt.sa_high = merge16(st_r.sa_high, wdata16, pstrb[1:0]);
				ptp_cfg_pkg::IDX_SA_LOW:
					st_nxt.sa_low = merge16(st_r.sa_low, wdata16, pstrb[1:0]);
				ptp_cfg_pkg::IDX_TRD_LOW:
					st_nxt.dur_low = merge16(st_r.dur_low, wdata16, pstrb[1:0]);
				ptp_cfg_pkg::IDX_TRD_HIGH:
					st_nxt.dur_high = ptp_cfg_pkg::DUR_HIGH_W'(merge16(
						{6'h00, st_r.dur_high}, wdata16, pstrb[1:0]));
				ptp_cfg_pkg::IDX_RATE_HIGH:
					st_nxt.rate_high = merge16(st_r.rate_high, wdata16, pstrb[1:0]);
				ptp_cfg_pkg::IDX_RATE_LOW:
				begin
					st_nxt.rate_low = merge16(st_r.rate_low, wdata16, pstrb[1:0]);
					st_nxt.start    = 1'b1;
				end
				default:
					st_nxt.start = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r                  <= '0;
			st_r.page             <= ptp_cfg_pkg::PAGE_RESET;
			st_r.coc.enable       <= ptp_cfg_pkg::COC_EN_RESET;
			st_r.coc.root_select  <= ptp_cfg_pkg::COC_SEL_RESET;
			st_r.coc.divide       <= ptp_cfg_pkg::DIV_RESET;
		end
		else
			st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// Sub-blocks
	// ----------------------------------------------------------------
	sync_clock_divider u_divider
	(
		.clk        (clk),
		.rst        (rst),
		.cfg        (st_r.coc),
		.sync_clk_r (sync_clk_out)
	);

	temp_rate_counter #(.DUR_W(ptp_cfg_pkg::DUR_W)) u_rate_timer
	(
		.clk      (clk),
		.rst      (rst),
		.start    (st_r.start),
		.duration ({st_r.dur_high, st_r.dur_low}),
		.active_r (rate_active)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata           = st_r.prdata;
	assign pready           = st_r.pready;
	assign pslverr          = st_r.pslverr;
	assign clk_out_cfg      = st_r.coc;
	assign status_header    = st_r.hdr;
	assign status_source_addr = {st_r.sa_high[7:0], st_r.sa_high[15:8],
		st_r.sa_low[7:0], st_r.sa_low[15:8]};
	assign temp_rate_value  = {st_r.rate_high, st_r.rate_low};
	assign temp_rate_active = rate_active;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence seq_write_idx(logic [ptp_cfg_pkg::IDX_W-1:0] i);
		psel && penable && pready && pwrite && idx == i && pstrb == 4'hF;
	endsequence

	sequence seq_read_idx(logic [ptp_cfg_pkg::IDX_W-1:0] i);
		psel && penable && !pready && !pwrite && idx == i;
	endsequence

	AST_RESET_COC: assert property (@(posedge clk)
		$past(rst) |-> clk_out_cfg.enable && !clk_out_cfg.root_select
			&& clk_out_cfg.divide == 8'h0A)
		else $error("clock output control reset value wrong");
	AST_PAGE_GATE: assert property (@(posedge clk) disable iff (rst)
		seq_write_idx(ptp_cfg_pkg::IDX_COC) ##0 (st_r.page != 3'h6)
			|=> $stable(clk_out_cfg))
		else $error("control written outside page six");
	AST_COC_WRITE: assert property (@(posedge clk) disable iff (rst)
		seq_write_idx(ptp_cfg_pkg::IDX_COC) ##0 (st_r.page == 3'h6)
			|=> clk_out_cfg.root_select == $past(pwdata[14])
			&& clk_out_cfg.divide == $past(pwdata[7:0]))
		else $error("control write not stored");
	AST_TRDH_RESERVED: assert property (@(posedge clk) disable iff (rst)
		seq_read_idx(ptp_cfg_pkg::IDX_TRD_HIGH) ##0 (st_r.page == 3'h5)
			|=> pready && prdata[31:10] == 22'h000000)
		else $error("reserved duration bits read nonzero");
	AST_COC_RESERVED: assert property (@(posedge clk) disable iff (rst)
		seq_read_idx(ptp_cfg_pkg::IDX_COC) ##0 (st_r.page == 3'h6)
			|=> prdata[12:8] == 5'h00)
		else $error("reserved control bits read nonzero");
	AST_DUR_WRITE: assert property (@(posedge clk) disable iff (rst)
		seq_write_idx(ptp_cfg_pkg::IDX_TRD_LOW) ##0 (st_r.page == 3'h5)
			|=> st_r.dur_low == $past(pwdata[15:0]))
		else $error("low duration write not stored");
	AST_RATE_START: assert property (@(posedge clk) disable iff (rst)
		seq_write_idx(ptp_cfg_pkg::IDX_RATE_LOW) ##0
			({st_r.dur_high, st_r.dur_low} != 26'h0000000)
			|=> ##1 temp_rate_active)
		else $error("rate low write did not start the timer");
	AST_DUR_KEPT: assert property (@(posedge clk) disable iff (rst)
		$fell(temp_rate_active) |-> $stable({st_r.dur_high, st_r.dur_low}))
		else $error("duration changed as the temporary rate ended");
	AST_ANSWER_ONE: assert property (@(posedge clk) disable iff (rst)
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("answer not a single cycle after one wait");
	AST_ADDR_BYTES: assert property (@(posedge clk) disable iff (rst)
		status_source_addr.first == st_r.sa_high[7:0]
			&& status_source_addr.fourth == st_r.sa_low[15:8])
		else $error("source address byte order wrong");
	AST_ADDR_LOW: assert property (@(posedge clk) disable iff (rst)
		status_source_addr.third == st_r.sa_low[7:0]
			&& status_source_addr.second == st_r.sa_high[15:8])
		else $error("low source address byte order wrong");
	AST_PAGE_WRITE: assert property (@(posedge clk) disable iff (rst)
		seq_write_idx(ptp_cfg_pkg::IDX_PAGE_SELECT)
			|=> st_r.page == $past(pwdata[2:0]))
		else $error("page select write not stored");
	AST_REFUSED: assert property (@(posedge clk) disable iff (rst)
		psel && penable && !pready && !reg_mapped(idx, st_r.page)
			|=> pslverr && prdata == 32'h00000000)
		else $error("wrong-page access not refused");
	AST_HDR_WRITE: assert property (@(posedge clk) disable iff (rst)
		seq_write_idx(ptp_cfg_pkg::IDX_HEADER) ##0 (st_r.page == 3'h6)
			|=> status_header == $past(pwdata[15:0]))
		else $error("header write not passed on");
	AST_HIGH_WRITE: assert property (@(posedge clk) disable iff (rst)
		seq_write_idx(ptp_cfg_pkg::IDX_TRD_HIGH) ##0 (st_r.page == 3'h5)
			|=> st_r.dur_high == $past(pwdata[9:0]))
		else $error("high duration write not stored");
	AST_STATUS_READ: assert property (@(posedge clk) disable iff (rst)
		seq_read_idx(ptp_cfg_pkg::IDX_RATE_STATUS)
			|=> prdata[31:1] == 31'h0 && prdata[0] == $past(temp_rate_active))
		else $error("rate status read wrong");

endmodule
`default_nettype wire

//--- tb/ptp_config_register_bank_test.sv
// Self-checking bench for the time-sync configuration register bank.
// Assumes the APB slave answers with one wait state and pages gate access.
`timescale 1ns/1ps
`default_nettype none
module ptp_config_register_bank_test;
	logic                              clk;
	logic                              rst;
	logic                              psel;
	logic                              penable;
	logic                              pwrite;
	logic [ptp_cfg_pkg::ADDR_W-1:0]    paddr;
	logic [ptp_cfg_pkg::DATA_W-1:0]    pwdata;
	logic [3:0]                        pstrb;
	logic [ptp_cfg_pkg::DATA_W-1:0]    prdata;
	logic                              pready;
	logic                              pslverr;
	ptp_cfg_pkg::clk_out_cfg_s         clk_out_cfg;
	logic                              sync_clk_out;
	ptp_cfg_pkg::header_word_s         status_header;
	ptp_cfg_pkg::source_addr_s         status_source_addr;
	logic [2*ptp_cfg_pkg::REG_W-1:0]   temp_rate_value;
	logic                              temp_rate_active;
	int                                err_count;
	int                                comparisons;
	int                                cycles;

	ptp_config_register_bank dut
	(
		.clk                (clk),
		.rst                (rst),
		.psel               (psel),
		.penable            (penable),
		.pwrite             (pwrite),
		.paddr              (paddr),
		.pwdata             (pwdata),
		.pstrb              (pstrb),
		.prdata             (prdata),
		.pready             (pready),
		.pslverr            (pslverr),
		.clk_out_cfg        (clk_out_cfg),
		.sync_clk_out       (sync_clk_out),
		.status_header      (status_header),
		.status_source_addr (status_source_addr),
		.temp_rate_value    (temp_rate_value),
		.temp_rate_active   (temp_rate_active)
	);

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic complete_run;
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// APB master
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [5:0] idx,
		input logic [31:0] wd, input logic [3:0] st,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		pstrb   <= st;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Answer taken at the rising edge that sees pready high
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			err_count++;
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, d, 4'hF, r, e);
	endtask

	task automatic rdc(input string nm, input logic [5:0] idx,
		input logic [31:0] exp, input logic experr);
		logic [31:0] r;
		logic        e;
		apb(1'b0, idx, 32'h0, 4'hF, r, e);
		chk(nm, r, exp);
		chk({nm, "_err"}, {31'h0, e}, {31'h0, experr});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset;
		wr(ptp_cfg_pkg::IDX_PAGE_SELECT, 32'h6);
		rdc("page", ptp_cfg_pkg::IDX_PAGE_SELECT, 32'h6, 1'b0);
		rdc("coc", ptp_cfg_pkg::IDX_COC, 32'h800A, 1'b0);
		chk("cfg", {21'h0, clk_out_cfg}, 32'h40A);
		rdc("hdr", ptp_cfg_pkg::IDX_HEADER, 32'h0, 1'b0);
		rdc("sah", ptp_cfg_pkg::IDX_SA_HIGH, 32'h0, 1'b0);
		rdc("sal", ptp_cfg_pkg::IDX_SA_LOW, 32'h0, 1'b0);
	endtask

	task automatic test_paging;
		wr(ptp_cfg_pkg::IDX_PAGE_SELECT, 32'h0);
		wr(ptp_cfg_pkg::IDX_COC, 32'h0);
		rdc("coc_p0", ptp_cfg_pkg::IDX_COC, 32'h0, 1'b1);
		rdc("unmapped", 6'h30, 32'h0, 1'b1);
		wr(ptp_cfg_pkg::IDX_PAGE_SELECT, 32'h5);
		rdc("coc_p5", ptp_cfg_pkg::IDX_COC, 32'h0, 1'b1);
		rdc("trdl", ptp_cfg_pkg::IDX_TRD_LOW, 32'h0, 1'b0);
		rdc("trdh", ptp_cfg_pkg::IDX_TRD_HIGH, 32'h0, 1'b0);
		wr(ptp_cfg_pkg::IDX_PAGE_SELECT, 32'h6);
		rdc("trdl_p6", ptp_cfg_pkg::IDX_TRD_LOW, 32'h0, 1'b1);
		rdc("coc_kept", ptp_cfg_pkg::IDX_COC, 32'h800A, 1'b0);
	endtask

	task automatic test_fields;
		logic [31:0] r;
		logic        e;
		wr(ptp_cfg_pkg::IDX_COC, 32'hFFFF);
		rdc("coc_rsv", ptp_cfg_pkg::IDX_COC, 32'hE0FF, 1'b0);
		chk("cfg_all", {21'h0, clk_out_cfg}, 32'h7FF);
		wr(ptp_cfg_pkg::IDX_HEADER, 32'hABCD);
		@(posedge clk);
		chk("hdr_out", {16'h0, status_header}, 32'hABCD);
		apb(1'b1, ptp_cfg_pkg::IDX_HEADER, 32'h1234, 4'h1, r, e);
		rdc("hdr_strb", ptp_cfg_pkg::IDX_HEADER, 32'hAB34, 1'b0);
		wr(ptp_cfg_pkg::IDX_SA_HIGH, 32'h2211);
		wr(ptp_cfg_pkg::IDX_SA_LOW, 32'h4433);
		@(posedge clk);
		chk("sa_out", status_source_addr, 32'h11223344);
		rdc("sal_rd", ptp_cfg_pkg::IDX_SA_LOW, 32'h4433, 1'b0);
	endtask

	// Over whole periods the high count is fixed whatever the phase
	task automatic div_case(input logic [31:0] coc, input int win,
		input int exp);
		int hi;
		wr(ptp_cfg_pkg::IDX_COC, coc);
		repeat (4) @(posedge clk);
		hi = 0;
		repeat (win)
		begin
			@(negedge clk);
			if (sync_clk_out === 1'b1)
				hi++;
		end
		chk("div_high", hi, exp);
	endtask

	task automatic test_divider;
		div_case(32'h8004, 16, 8);
		div_case(32'h8003, 12, 4);
		div_case(32'h80FF, 255, 127);
		div_case(32'h8002, 8, 4);
		div_case(32'h8001, 16, 0);
		div_case(32'h8000, 16, 0);
		div_case(32'h0004, 16, 0);
	endtask

	// Rate low write, then count the cycles the timer stays active
	task automatic rate_run(input int exp);
		int act;
		wr(ptp_cfg_pkg::IDX_RATE_LOW, 32'h5678);
		act = 0;
		repeat (20)
		begin
			@(negedge clk);
			if (temp_rate_active === 1'b1)
				act++;
		end
		chk("active", act, exp);
	endtask

	task automatic test_temp_rate;
		wr(ptp_cfg_pkg::IDX_PAGE_SELECT, 32'h5);
		wr(ptp_cfg_pkg::IDX_TRD_HIGH, 32'hFFFF);
		rdc("trdh_rsv", ptp_cfg_pkg::IDX_TRD_HIGH, 32'h3FF, 1'b0);
		wr(ptp_cfg_pkg::IDX_TRD_HIGH, 32'h0);
		wr(ptp_cfg_pkg::IDX_TRD_LOW, 32'h5);
		wr(ptp_cfg_pkg::IDX_RATE_HIGH, 32'h1234);
		rate_run(5);
		rate_run(5);
		chk("rate", temp_rate_value, 32'h12345678);
		rdc("trdl_kept", ptp_cfg_pkg::IDX_TRD_LOW, 32'h5, 1'b0);
		wr(ptp_cfg_pkg::IDX_RATE_LOW, 32'h5678);
		rdc("stat_on", ptp_cfg_pkg::IDX_RATE_STATUS, 32'h1, 1'b0);
		repeat (10) @(posedge clk);
		rdc("stat_off", ptp_cfg_pkg::IDX_RATE_STATUS, 32'h0, 1'b0);
		wr(ptp_cfg_pkg::IDX_TRD_LOW, 32'h3);
		rate_run(3);
		wr(ptp_cfg_pkg::IDX_TRD_LOW, 32'h0);
		rate_run(0);
	endtask

	// ----------------------------------------------------------------
	// Clock, timeout and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			complete_run();
		end
	end

	initial
	begin
		err_count   = 0;
		comparisons = 0;
		cycles      = 0;
		rst     = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		pstrb   = 4'h0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		test_reset();
		test_paging();
		test_fields();
		test_divider();
		test_temp_rate();
		complete_run();
	end
endmodule
`default_nettype wire
